//--- design/dram_bank_scheduler.sv
// Command scheduler: bank engine pool, rank and column machines, row and column arbitration.
// Assumes requests and commands run on core_clk, one quarter of the memory clock.
//
// Contract
// - One engine owns one bank at once
// - Bind request to free engine, release after
// - Idle request: activate, column, precharge, release
// - Same-row follower: skip precharge and activate
// - Middle request needs neither activate nor precharge
// - Precharge early unless a queued request hits
// - Rank inhibits activates over window limit
// - Rank machines fixed to one rank
// - Column machine paces the shared data bus
// - At most one row, one column command
// - Round-robin grant among competing engines
// - Activate requested only when timing allows
// - Same open row inherits engine state
// - Every request issues column after row delay
// - Column needs state, bus, priority, order
// - Requests wait out refresh, then round-robin
// - Writes issue in request order
// - Same rank-bank requests retire in order
// - Close row when no queued request hits
// - Queue depth equals engine count
// - Commands exchanged in quarter-rate clock
// - Enforce timing, refresh, group reads writes
// - Column tag lets user layer reorder reads
module dram_bank_scheduler (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic                           normal_ordering_mode,
  input  wire logic                           req_valid,
  output logic                                req_ready,
  output logic [sched_pkg::ENG_W-1:0]         req_tag,
  input  wire logic                           req_write,
  input  wire logic [sched_pkg::RANK_W-1:0]   req_rank,
  input  wire logic [sched_pkg::BANK_W-1:0]   req_bank,
  input  wire logic [sched_pkg::ROW_W-1:0]    req_row,
  output logic                                row_cmd_valid,
  output sched_pkg::row_cmd_e                 row_cmd_kind,
  output logic [sched_pkg::RANK_W-1:0]        row_cmd_rank,
  output logic [sched_pkg::BANK_W-1:0]        row_cmd_bank,
  output logic [sched_pkg::ROW_W-1:0]         row_cmd_row,
  output logic                                col_cmd_valid,
  output logic                                col_cmd_write,
  output logic [sched_pkg::RANK_W-1:0]        col_cmd_rank,
  output logic [sched_pkg::BANK_W-1:0]        col_cmd_bank,
  output logic [sched_pkg::ENG_W-1:0]         col_cmd_tag
);

  localparam int N = sched_pkg::NUM_ENG;

  function automatic logic [sched_pkg::ENG_W-1:0] first_set(input logic [N-1:0] v);
    logic [sched_pkg::ENG_W-1:0] idx;
    idx = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = sched_pkg::ENG_W'(k);
      end
    end
    return idx;
  endfunction

  logic rst_meta_ff;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'h0;
      rst_sync_n  <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_sync_n  <= rst_meta_ff;
    end
  end

  sched_pkg::eng_state_e         st_ff   [N];
  logic [sched_pkg::RANK_W-1:0]  rank_ff [N];
  logic [sched_pkg::BANK_W-1:0]  bank_ff [N];
  logic [sched_pkg::ROW_W-1:0]   row_ff  [N];
  logic [sched_pkg::ENG_W-1:0]   pred_ff [N];
  logic [sched_pkg::TMR_W-1:0]   tmr_ff  [N];
  logic [sched_pkg::TMR_W-1:0]   ras_ff  [N];
  logic [N-1:0]                  older_ff[N];
  logic [N-1:0]                  wr_ff;
  logic [N-1:0]                  haspred_ff;
  logic [N-1:0]                  inh_ff;

  logic [N-1:0] busy;
  logic [N-1:0] open_st;
  logic [N-1:0] live_st;
  logic [N-1:0] col_pend;
  logic [N-1:0] same_bank;
  logic [N-1:0] succ_any;
  logic [N-1:0] succ_inh;
  logic [N-1:0] tail;
  logic [N-1:0] row_req;
  logic [N-1:0] col_req;
  logic [N-1:0] col_hi;

  logic [sched_pkg::ENG_W-1:0]  alloc_idx;
  logic [sched_pkg::ENG_W-1:0]  tail_idx;
  logic                         tail_hit;
  logic                         can_inherit;
  logic                         accept;
  logic [sched_pkg::NUM_RANK-1:0] act_inhibit;
  logic                         rd_inhibit;
  logic                         wr_inhibit;
  logic                         ref_block;
  logic                         ref_go;

  arb_if row_bus ();
  arb_if col_bus ();

  generate
    for (genvar i = 0; i < N; i++) begin : g_flags
      assign busy[i]     = st_ff[i] != sched_pkg::E_IDLE;
      assign open_st[i]  = st_ff[i] inside {sched_pkg::E_RCD, sched_pkg::E_COL,
                                            sched_pkg::E_HOLD, sched_pkg::E_PRE,
                                            sched_pkg::E_RP};
      assign live_st[i]  = st_ff[i] inside {sched_pkg::E_WAIT, sched_pkg::E_ACT,
                                            sched_pkg::E_RCD, sched_pkg::E_COL,
                                            sched_pkg::E_HOLD};
      assign col_pend[i] = st_ff[i] inside {sched_pkg::E_WAIT, sched_pkg::E_ACT,
                                            sched_pkg::E_RCD, sched_pkg::E_COL};
      assign same_bank[i] = busy[i] && rank_ff[i] == req_rank && bank_ff[i] == req_bank;
      always_comb begin
        succ_any[i] = 1'h0;
        succ_inh[i] = 1'h0;
        for (int j = 0; j < N; j++) begin
          if (st_ff[j] == sched_pkg::E_WAIT && haspred_ff[j] &&
              pred_ff[j] == sched_pkg::ENG_W'(i)) begin
            succ_any[i] = 1'h1;
            succ_inh[i] = succ_inh[i] | inh_ff[j];
          end
        end
      end
      assign tail[i] = same_bank[i] && !succ_any[i];
    end
  endgenerate

  assign alloc_idx = first_set(~busy);
  assign req_ready = |(~busy);
  assign req_tag   = alloc_idx;
  assign accept    = req_valid && req_ready;
  assign tail_idx  = first_set(tail);
  assign tail_hit  = |tail;
  assign can_inherit = tail_hit && live_st[tail_idx] && row_ff[tail_idx] == req_row &&
                       !ref_block;

  // Row requests: activates gated by rank window and refresh, precharges always.
  generate
    for (genvar i = 0; i < N; i++) begin : g_req
      logic older_wr_pend;
      logic older_any_pend;
      assign older_wr_pend  = |(older_ff[i] & wr_ff & col_pend);
      assign older_any_pend = |(older_ff[i] & col_pend);
      assign row_req[i] = (st_ff[i] == sched_pkg::E_ACT && !act_inhibit[rank_ff[i]] &&
                           !ref_block) || st_ff[i] == sched_pkg::E_PRE;
      // column gated by bus and order
      assign col_req[i] = st_ff[i] == sched_pkg::E_COL &&
                          !(wr_ff[i] ? wr_inhibit : rd_inhibit) &&
                          !(wr_ff[i] && older_wr_pend) &&
                          !(!normal_ordering_mode && older_any_pend);
    end
  endgenerate

  // Column machine: spacing and turnaround since the last column command.
  logic                         last_wr_ff;
  logic [sched_pkg::GAP_W-1:0]  gap_ff;
  logic [sched_pkg::CNT_W-1:0]  streak_ff;
  logic                         group_open;

  assign rd_inhibit = gap_ff < (last_wr_ff ? sched_pkg::WTR_GAP : sched_pkg::CCD_GAP);
  assign wr_inhibit = gap_ff < (last_wr_ff ? sched_pkg::CCD_GAP : sched_pkg::RTW_GAP);
  assign group_open = streak_ff < sched_pkg::GRP_LIMIT;
  assign col_hi = col_req & (last_wr_ff ? wr_ff : ~wr_ff);
  assign row_bus.req = row_req;
  assign col_bus.req = (group_open && |col_hi) ? col_hi : col_req;

  rr_arbiter u_row_arb (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .arb        (row_bus)
  );

  rr_arbiter u_col_arb (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .arb        (col_bus)
  );

  logic [sched_pkg::ENG_W-1:0] rg;
  logic [sched_pkg::ENG_W-1:0] cg;
  logic                        row_win;
  logic                        col_win;
  logic                        col_wr;
  assign rg      = row_bus.grant_idx;
  assign cg      = col_bus.grant_idx;
  assign row_win = row_bus.grant_valid;
  assign col_win = col_bus.grant_valid;
  assign col_wr  = wr_ff[cg];

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      last_wr_ff <= 1'h0;
      gap_ff     <= '1;
      streak_ff  <= '0;
    end else if (col_win) begin
      last_wr_ff <= col_wr;
      gap_ff     <= 3'h1;
      streak_ff  <= (col_wr == last_wr_ff && group_open) ? streak_ff + 4'h1 : 4'h1;
    end else if (gap_ff != '1) begin
      gap_ff <= gap_ff + 3'h1;
    end
  end

  // Rank machines: activate history per rank over the four-activate window.
  generate
    for (genvar r = 0; r < sched_pkg::NUM_RANK; r++) begin : g_rank
      logic [sched_pkg::FAW_CYC-1:0] hist_ff;
      logic [sched_pkg::CNT_W-1:0]   acts;
      logic                          act_here;
      assign act_here = row_win && st_ff[rg] == sched_pkg::E_ACT &&
                        rank_ff[rg] == sched_pkg::RANK_W'(r);
      always_comb begin
        acts = '0;
        for (int k = 0; k < sched_pkg::FAW_CYC; k++) begin
          acts = acts + sched_pkg::CNT_W'(hist_ff[k]);
        end
      end
      assign act_inhibit[r] = acts >= sched_pkg::FAW_LIMIT;
      always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          hist_ff <= '0;
        end else begin
          hist_ff <= {hist_ff[sched_pkg::FAW_CYC-2:0], act_here};
        end
      end
    end
  endgenerate

  // Refresh waits for every bank to close; new activates hold off meanwhile.
  logic                         ref_need_ff;
  logic [sched_pkg::REFI_W-1:0] refi_ff;
  logic [sched_pkg::RFC_W-1:0]  rfc_ff;

  assign ref_block = ref_need_ff || rfc_ff != '0;
  assign ref_go    = ref_need_ff && !(|open_st) && rfc_ff == '0;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_need_ff <= 1'h0;
      refi_ff     <= sched_pkg::REFI_LOAD;
      rfc_ff      <= '0;
    end else begin
      refi_ff     <= (refi_ff == '0) ? sched_pkg::REFI_LOAD : refi_ff - 10'h001;
      ref_need_ff <= (refi_ff == '0) || (ref_need_ff && !ref_go);
      rfc_ff      <= ref_go ? sched_pkg::RFC_LOAD : (rfc_ff != '0 ? rfc_ff - 5'h01 : rfc_ff);
    end
  end

  // Bank engines.
  generate
    for (genvar i = 0; i < N; i++) begin : g_eng
      sched_pkg::eng_state_e        nxt_st;
      logic [sched_pkg::TMR_W-1:0]  nxt_tmr;
      logic [sched_pkg::TMR_W-1:0]  nxt_ras;
      logic                         mine;
      logic                         pre_go;
      assign mine = accept && alloc_idx == sched_pkg::ENG_W'(i);
      assign pre_go = ras_ff[i] >= sched_pkg::RAS_MIN && !succ_inh[i] &&
                      !(accept && can_inherit && tail_idx == sched_pkg::ENG_W'(i));
      always_comb begin
        nxt_st  = st_ff[i];
        nxt_tmr = tmr_ff[i];
        nxt_ras = (ras_ff[i] != '1) ? ras_ff[i] + 4'h1 : ras_ff[i];
        case (st_ff[i])
          sched_pkg::E_IDLE: begin
            if (mine) begin
              nxt_st = tail_hit ? sched_pkg::E_WAIT : sched_pkg::E_ACT;
            end
          end
          sched_pkg::E_WAIT: begin
            if (inh_ff[i] && st_ff[pred_ff[i]] == sched_pkg::E_HOLD) begin
              nxt_st  = sched_pkg::E_COL;
              nxt_ras = ras_ff[pred_ff[i]];
            end else if (!inh_ff[i] && st_ff[pred_ff[i]] == sched_pkg::E_IDLE) begin
              nxt_st = sched_pkg::E_ACT;
            end
          end
          sched_pkg::E_ACT: begin
            if (row_win && rg == sched_pkg::ENG_W'(i)) begin
              nxt_st  = sched_pkg::E_RCD;
              nxt_tmr = sched_pkg::RCD_LOAD;
              nxt_ras = '0;
            end
          end
          sched_pkg::E_RCD: begin
            if (tmr_ff[i] == '0) begin
              nxt_st = sched_pkg::E_COL;
            end else begin
              nxt_tmr = tmr_ff[i] - 4'h1;
            end
          end
          sched_pkg::E_COL: begin
            if (col_win && cg == sched_pkg::ENG_W'(i)) begin
              nxt_st = sched_pkg::E_HOLD;
            end
          end
          sched_pkg::E_HOLD: begin
            if (succ_inh[i]) begin
              nxt_st = sched_pkg::E_IDLE;
            end else if (pre_go) begin
              nxt_st = sched_pkg::E_PRE;
            end
          end
          sched_pkg::E_PRE: begin
            if (row_win && rg == sched_pkg::ENG_W'(i)) begin
              nxt_st  = sched_pkg::E_RP;
              nxt_tmr = sched_pkg::RP_LOAD;
            end
          end
          sched_pkg::E_RP: begin
            if (tmr_ff[i] == '0) begin
              nxt_st = sched_pkg::E_IDLE;
            end else begin
              nxt_tmr = tmr_ff[i] - 4'h1;
            end
          end
          default: begin
            nxt_st = sched_pkg::E_IDLE;
          end
        endcase
      end

      always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          st_ff[i]      <= sched_pkg::E_IDLE;
          tmr_ff[i]     <= '0;
          ras_ff[i]     <= '0;
          older_ff[i]   <= '0;
          rank_ff[i]    <= '0;
          bank_ff[i]    <= '0;
          row_ff[i]     <= '0;
          pred_ff[i]    <= '0;
          wr_ff[i]      <= 1'h0;
          haspred_ff[i] <= 1'h0;
          inh_ff[i]     <= 1'h0;
        end else begin
          st_ff[i]    <= nxt_st;
          tmr_ff[i]   <= nxt_tmr;
          ras_ff[i]   <= nxt_ras;
          older_ff[i] <= mine ? busy : (older_ff[i] & busy);
          if (mine) begin
            rank_ff[i]    <= req_rank;
            bank_ff[i]    <= req_bank;
            row_ff[i]     <= req_row;
            wr_ff[i]      <= req_write;
            pred_ff[i]    <= tail_idx;
            haspred_ff[i] <= tail_hit;
            inh_ff[i]     <= can_inherit;
          end else if (nxt_st != sched_pkg::E_WAIT) begin
            haspred_ff[i] <= 1'h0;
          end
        end
      end
    end
  endgenerate

  // Command outputs, one row and one column slot per scheduler cycle.
  logic                         row_v_ff;
  sched_pkg::row_cmd_e          row_k_ff;
  logic [sched_pkg::RANK_W-1:0] row_rk_ff;
  logic [sched_pkg::BANK_W-1:0] row_bk_ff;
  logic [sched_pkg::ROW_W-1:0]  row_rw_ff;
  logic                         col_v_ff;
  logic                         col_w_ff;
  logic [sched_pkg::RANK_W-1:0] col_rk_ff;
  logic [sched_pkg::BANK_W-1:0] col_bk_ff;
  logic [sched_pkg::ENG_W-1:0]  col_tg_ff;
  sched_pkg::row_cmd_e          nxt_row_k;

  assign nxt_row_k = ref_go ? sched_pkg::RC_REF :
                     !row_win ? sched_pkg::RC_NONE :
                     (st_ff[rg] == sched_pkg::E_ACT) ? sched_pkg::RC_ACT : sched_pkg::RC_PRE;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      row_v_ff  <= 1'h0;
      row_k_ff  <= sched_pkg::RC_NONE;
      row_rk_ff <= '0;
      row_bk_ff <= '0;
      row_rw_ff <= '0;
      col_v_ff  <= 1'h0;
      col_w_ff  <= 1'h0;
      col_rk_ff <= '0;
      col_bk_ff <= '0;
      col_tg_ff <= '0;
    end else begin
      row_v_ff  <= ref_go || row_win;
      row_k_ff  <= nxt_row_k;
      row_rk_ff <= rank_ff[rg];
      row_bk_ff <= bank_ff[rg];
      row_rw_ff <= row_ff[rg];
      col_v_ff  <= col_win;
      col_w_ff  <= col_wr;
      col_rk_ff <= rank_ff[cg];
      col_bk_ff <= bank_ff[cg];
      col_tg_ff <= cg;
    end
  end

  assign row_cmd_valid = row_v_ff;
  assign row_cmd_kind  = row_k_ff;
  assign row_cmd_rank  = row_rk_ff;
  assign row_cmd_bank  = row_bk_ff;
  assign row_cmd_row   = row_rw_ff;
  assign col_cmd_valid = col_v_ff;
  assign col_cmd_write = col_w_ff;
  assign col_cmd_rank  = col_rk_ff;
  assign col_cmd_bank  = col_bk_ff;
  assign col_cmd_tag   = col_tg_ff;

endmodule

//--- shared/sched_pkg.sv
// Shared constants, state and command encodings for the bank scheduler.
// Assumes a single 200 MHz scheduler clock, one quarter of the memory clock.
package sched_pkg;

  localparam int NUM_ENG  = 4;
  localparam int ENG_W    = 2;
  localparam int NUM_RANK = 2;
  localparam int RANK_W   = 1;
  localparam int BANK_W   = 3;
  localparam int ROW_W    = 15;

  localparam int CLK_MHZ  = 200;
  localparam int MEM_CLK_RATIO = 4;

  // Device timing in picoseconds, converted to scheduler cycles below.
  localparam int T_RCD_PS  = 18000;
  localparam int T_RP_PS   = 18000;
  localparam int T_RAS_PS  = 42000;
  localparam int T_FAW_PS  = 50000;
  localparam int T_RFC_PS  = 130000;
  localparam int T_WTR_PS  = 7500;
  localparam int T_RTW_PS  = 10000;
  localparam int T_REFI_PS = 3900000;

  localparam int RCD_CYC  = (T_RCD_PS * CLK_MHZ + 999999) / 1000000;
  localparam int RP_CYC   = (T_RP_PS * CLK_MHZ + 999999) / 1000000;
  localparam int RAS_CYC  = (T_RAS_PS * CLK_MHZ + 999999) / 1000000;
  localparam int FAW_CYC  = (T_FAW_PS * CLK_MHZ + 999999) / 1000000;
  localparam int RFC_CYC  = (T_RFC_PS * CLK_MHZ + 999999) / 1000000;
  localparam int WTR_CYC  = (T_WTR_PS * CLK_MHZ + 999999) / 1000000;
  localparam int RTW_CYC  = (T_RTW_PS * CLK_MHZ + 999999) / 1000000;
  localparam int REFI_CYC = (T_REFI_PS * CLK_MHZ) / 1000000;
  localparam int CCD_CYC  = 1;

  localparam int FAW_ACTS  = 4;
  localparam int GROUP_MAX = 8;

  localparam int TMR_W  = 4;
  localparam int GAP_W  = 3;
  localparam int RFC_W  = 5;
  localparam int REFI_W = 10;
  localparam int CNT_W  = 4;

  localparam logic [TMR_W-1:0]  RCD_LOAD  = TMR_W'(RCD_CYC - 1);
  localparam logic [TMR_W-1:0]  RP_LOAD   = TMR_W'(RP_CYC - 1);
  localparam logic [TMR_W-1:0]  RAS_MIN   = TMR_W'(RAS_CYC);
  localparam logic [GAP_W-1:0]  WTR_GAP   = GAP_W'(WTR_CYC);
  localparam logic [GAP_W-1:0]  RTW_GAP   = GAP_W'(RTW_CYC);
  localparam logic [GAP_W-1:0]  CCD_GAP   = GAP_W'(CCD_CYC);
  localparam logic [RFC_W-1:0]  RFC_LOAD  = RFC_W'(RFC_CYC);
  localparam logic [REFI_W-1:0] REFI_LOAD = REFI_W'(REFI_CYC - 1);
  localparam logic [CNT_W-1:0]  FAW_LIMIT = CNT_W'(FAW_ACTS);
  localparam logic [CNT_W-1:0]  GRP_LIMIT = CNT_W'(GROUP_MAX);

  typedef enum logic [2:0] {
    E_IDLE, E_WAIT, E_ACT, E_RCD, E_COL, E_HOLD, E_PRE, E_RP
  } eng_state_e;

  typedef enum logic [1:0] {
    RC_NONE, RC_ACT, RC_PRE, RC_REF
  } row_cmd_e;

endpackage

//--- shared/arb_if.sv
// Request and grant bundle between the scheduler and a round-robin arbiter.
// Assumes both ends run on the scheduler clock.
interface arb_if;
  logic [sched_pkg::NUM_ENG-1:0] req;
  logic                          grant_valid;
  logic [sched_pkg::ENG_W-1:0]   grant_idx;

  modport client  (output req, input grant_valid, input grant_idx);
  modport arbiter (input req, output grant_valid, output grant_idx);
endinterface

//--- design/rr_arbiter.sv
// Round-robin arbiter over the bank engines, one grant per cycle.
// Assumes the engine count is a power of two so the index wraps naturally.
module rr_arbiter (
  input  wire logic core_clk,
  input  wire logic rst_sync_n,
  arb_if.arbiter    arb
);

  logic [sched_pkg::ENG_W-1:0] ptr_ff;
  logic [sched_pkg::ENG_W-1:0] nxt_ptr;

  always_comb begin
    logic                        found;
    logic [sched_pkg::ENG_W-1:0] cand;
    found = 1'h0;
    cand  = '0;
    arb.grant_valid = 1'h0;
    arb.grant_idx   = '0;
    for (int k = 0; k < sched_pkg::NUM_ENG; k++) begin
      cand = ptr_ff + sched_pkg::ENG_W'(k);
      if (!found && arb.req[cand]) begin
        found = 1'h1;
        arb.grant_valid = 1'h1;
        arb.grant_idx   = cand;
      end
    end
  end

  assign nxt_ptr = arb.grant_valid ? arb.grant_idx + 2'h1 : ptr_ff;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

endmodule

//--- dv/dram_bank_scheduler_monitor.sv
// Checker for the scheduler's command ports: bank state, timing and data bus gaps.
// Assumes one core_clk domain with rst_n as its only reset.
module dram_bank_scheduler_monitor (
  input wire logic                         core_clk,
  input wire logic                         rst_n,
  input wire logic                         row_cmd_valid,
  input wire sched_pkg::row_cmd_e          row_cmd_kind,
  input wire logic [sched_pkg::RANK_W-1:0] row_cmd_rank,
  input wire logic [sched_pkg::BANK_W-1:0] row_cmd_bank,
  input wire logic                         col_cmd_valid,
  input wire logic                         col_cmd_write,
  input wire logic [sched_pkg::RANK_W-1:0] col_cmd_rank,
  input wire logic [sched_pkg::BANK_W-1:0] col_cmd_bank
);
  logic [4:0]  age_ff [16];
  logic [15:0] open_ff;
  logic [4:0]  ref_ff;
  logic [8:0]  act_ff [2];
  wire act = row_cmd_valid && row_cmd_kind == sched_pkg::RC_ACT;
  wire pre = row_cmd_valid && row_cmd_kind == sched_pkg::RC_PRE;
  wire rfs = row_cmd_valid && row_cmd_kind == sched_pkg::RC_REF;
  wire [3:0] rb = {row_cmd_rank, row_cmd_bank};
  wire [3:0] cb = {col_cmd_rank, col_cmd_bank};
  // Ages saturate at 31 so that a bank idle since reset meets every limit.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_ff <= 16'h0000;
      ref_ff <= 5'h1F;
      act_ff <= '{default: 9'h000};
      age_ff <= '{default: 5'h1F};
    end else begin
      if (act) open_ff[rb] <= 1'h1;
      if (pre) open_ff[rb] <= 1'h0;
      ref_ff <= rfs ? 5'h01 : ref_ff + 5'(ref_ff != 5'h1F);
      for (int r = 0; r < 2; r++) act_ff[r] <= {act_ff[r][7:0], act && row_cmd_rank == r};
      for (int i = 0; i < 16; i++)
        age_ff[i] <= ((act || pre) && rb == i) ? 5'h01 : age_ff[i] + 5'(age_ff[i] != 5'h1F);
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_act_closed_bank: assert property (act |-> !open_ff[rb])
    else $error("activate to a bank already open");
  chk_col_open_bank: assert property (col_cmd_valid |-> open_ff[cb])
    else $error("column command to a closed bank");
  chk_col_after_rcd: assert property (
    col_cmd_valid |-> age_ff[cb] >= sched_pkg::RCD_CYC)
    else $error("column command before row delay");
  chk_pre_after_ras: assert property (
    pre |-> open_ff[rb] && age_ff[rb] >= sched_pkg::RAS_CYC)
    else $error("precharge too early or to a closed bank");
  chk_act_after_rp: assert property (act |-> age_ff[rb] >= sched_pkg::RP_CYC)
    else $error("activate before precharge delay");
  chk_act_window_limit: assert property (
    act |-> $countones(act_ff[row_cmd_rank]) < sched_pkg::FAW_ACTS)
    else $error("too many activates in window");
  chk_ref_all_closed: assert property (rfs |-> open_ff == 16'h0000)
    else $error("refresh with a bank open");
  chk_act_after_ref: assert property (act |-> ref_ff >= sched_pkg::RFC_CYC)
    else $error("activate during refresh");
  chk_wr_rd_gap: assert property (
    col_cmd_valid && col_cmd_write |=> !(col_cmd_valid && !col_cmd_write))
    else $error("read too soon after write");
  chk_rd_wr_gap: assert property (
    col_cmd_valid && !col_cmd_write |=> !(col_cmd_valid && col_cmd_write))
    else $error("write too soon after read");
  cover property (rfs);
  cover property (act ##[1:20] col_cmd_valid);
  cover property (col_cmd_valid && col_cmd_write ##1 col_cmd_valid);
endmodule
bind dram_bank_scheduler dram_bank_scheduler_monitor mon_u (.core_clk(core_clk), .rst_n(rst_n),
  .row_cmd_valid(row_cmd_valid), .row_cmd_kind(row_cmd_kind), .row_cmd_rank(row_cmd_rank),
  .row_cmd_bank(row_cmd_bank), .col_cmd_valid(col_cmd_valid), .col_cmd_write(col_cmd_write),
  .col_cmd_rank(col_cmd_rank), .col_cmd_bank(col_cmd_bank));

//--- dv/phy_model.sv
// Physical-layer stand-in: takes every command, counts each kind and logs the column commands.
// Assumes commands are sampled on core_clk; it never pushes back.
module phy_model (
  input wire logic                        core_clk,
  input wire logic                        rst_n,
  input wire logic                        row_cmd_valid,
  input wire sched_pkg::row_cmd_e         row_cmd_kind,
  input wire logic                        col_cmd_valid,
  input wire logic                        col_cmd_write,
  input wire logic [sched_pkg::ENG_W-1:0] col_cmd_tag,
  output logic [15:0]                     act_cnt,
  output logic [15:0]                     pre_cnt,
  output logic [15:0]                     ref_cnt,
  output logic [15:0]                     col_cnt,
  output logic [2:0]                      col_log [8]
);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {act_cnt, pre_cnt, ref_cnt, col_cnt} <= 64'h0;
    end else begin
      if (row_cmd_valid && row_cmd_kind == sched_pkg::RC_ACT) act_cnt <= act_cnt + 16'h0001;
      if (row_cmd_valid && row_cmd_kind == sched_pkg::RC_PRE) pre_cnt <= pre_cnt + 16'h0001;
      if (row_cmd_valid && row_cmd_kind == sched_pkg::RC_REF) ref_cnt <= ref_cnt + 16'h0001;
      if (col_cmd_valid) begin
        col_log[col_cnt[2:0]] <= {col_cmd_write, col_cmd_tag};
        col_cnt <= col_cnt + 16'h0001;
      end
    end
  end
endmodule

//--- dv/dram_bank_scheduler_bench.sv
// Bench for the scheduler: directed request sequences judged by command counts and order.
// Assumes phy_model and the bound monitor are compiled alongside.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dram_bank_scheduler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, mode = 1, req_valid = 0, req_write = 0;
  logic [3:0] rbk = 4'h0;
  logic [14:0] req_row = 15'h0000;
  wire rdy, rv, cv, cw;
  wire [1:0] tag, ct;
  wire sched_pkg::row_cmd_e rk;
  wire [15:0] na, np, nr, nc;
  wire [2:0] clog [8];
  wire [14:0] arow;
  logic [14:0] last_act;
  int fail_count, compares, cyc, ea, ep, ec;
  logic [2:0] exp_log [4];
  dram_bank_scheduler dut_u (.core_clk(core_clk), .rst_n(rst_n), .normal_ordering_mode(mode),
    .req_valid(req_valid), .req_ready(rdy), .req_tag(tag), .req_write(req_write),
    .req_rank(rbk[3]), .req_bank(rbk[2:0]), .req_row(req_row), .row_cmd_valid(rv),
    .row_cmd_kind(rk), .row_cmd_rank(), .row_cmd_bank(), .row_cmd_row(arow), .col_cmd_valid(cv),
    .col_cmd_write(cw), .col_cmd_rank(), .col_cmd_bank(), .col_cmd_tag(ct));
  phy_model phy_u (.core_clk(core_clk), .rst_n(rst_n), .row_cmd_valid(rv), .row_cmd_kind(rk),
    .col_cmd_valid(cv), .col_cmd_write(cw), .col_cmd_tag(ct), .act_cnt(na), .pre_cnt(np),
    .ref_cnt(nr), .col_cnt(nc), .col_log(clog));
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (rv && rk == sched_pkg::RC_ACT) last_act <= arow;
    if (cyc == 9000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic send(input logic w, input logic [3:0] b, input logic [14:0] r, input int k);
    @(negedge core_clk);
    req_valid = 1;
    req_write = w;
    rbk = b;
    req_row = r;
    while (rdy !== 1'b1) @(negedge core_clk);
    exp_log[k] = {w, tag};
    @(posedge core_clk);
  endtask
  // Waits for the expected precharges, columns and a free engine, then judges counts and column order.
  task automatic finish_test(input int n, input int a, input int p);
    @(negedge core_clk);
    req_valid = 0;
    ea += a;
    ep += p;
    ec += n;
    for (int i = 0; i < 300 && !(np == ep && nc == ec && rdy === 1'b1); i++) @(negedge core_clk);
    `CHK(na, 16'(ea))
    `CHK(np, 16'(ep))
    `CHK(nc, 16'(ec))
    for (int k = 0; k < n; k++) `CHK(clog[3'(ec - n + k)], exp_log[k])
    $display("test with %0d requests done", n);
  endtask
  task automatic complete_run;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic test_single;
    send(0, 4'h1, 15'h0005, 0);
    `CHK(exp_log[0], 3'h0)
    finish_test(1, 1, 1);
    `CHK(last_act, 15'h0005)
  endtask
  // Three hits on one open row: only the last one closes it.
  task automatic test_same_row;
    send(1, 4'h2, 15'h0AAA, 0);
    send(1, 4'h2, 15'h0AAA, 1);
    send(1, 4'h2, 15'h0AAA, 2);
    finish_test(3, 1, 1);
  endtask
  task automatic test_new_row;
    send(0, 4'h3, 15'h0011, 0);
    send(1, 4'h3, 15'h7FFF, 1);
    finish_test(2, 2, 2);
    `CHK(last_act, 15'h7FFF)
  endtask
  task automatic test_full_queue;
    mode = 0;
    for (int k = 0; k < 4; k++) send(1'(k), 4'(12 + k), 15'(k), k);
    @(negedge core_clk);
    `CHK(rdy, 1'b0)
    finish_test(4, 4, 4);
    mode = 1;
  endtask
  task automatic test_refresh;
    for (int i = 0; i < 900 && nr === 16'h0000; i++) @(negedge core_clk);
    `CHK(nr, 16'h0001)
    send(0, 4'h5, 15'h0123, 0);
    finish_test(1, 1, 1);
  endtask
  initial begin
    repeat (9) @(negedge core_clk);
    rst_n = 1;
    repeat (3) @(negedge core_clk);
    test_single();
    test_same_row();
    test_new_row();
    test_full_queue();
    test_refresh();
    complete_run();
  end
endmodule
